// [hw/ccsys_consts.svh]
`ifndef CCSYS_CONSTS_SVH
`define CCSYS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CCSYS_ADDR_W          8
`define CCSYS_OFS_ROUTING     8'h8C
`define CCSYS_OFS_SYSCTL      8'h80

// ----------------------------------------------------------------------
// System control field positions
// ----------------------------------------------------------------------
`define CCSYS_B_STREAM        11
`define CCSYS_B_UPWAIT        10
`define CCSYS_B_DNWAIT        9
`define CCSYS_B_PROBE         8
`define CCSYS_B_GATE          6
`define CCSYS_B_IDLOCK        5
`define CCSYS_B_PARSERR       4
`define CCSYS_B_CDMA          3
`define CCSYS_B_HOLD          1
`define CCSYS_B_RING_PME_MUX  0
`define CCSYS_SYSCTL_WMASK    32'h0000007B
`define CCSYS_SYSCTL_RST      32'h00000020

// ----------------------------------------------------------------------
// Routing register layout
// ----------------------------------------------------------------------
`define CCSYS_ROUTE_WMASK     32'h0FFFFFFF
`define CCSYS_ROUTE_RST       32'h00000000
`define CCSYS_MP6_LSB         24
`define CCSYS_MP6_CLKRUN      4'h1

// ----------------------------------------------------------------------
// Power switch settling delays
// ----------------------------------------------------------------------
`define CCSYS_CLK_MHZ         50
`define CCSYS_UP_DELAY_US     40
`define CCSYS_DN_DELAY_US     40
`define CCSYS_UP_CYC          (`CCSYS_UP_DELAY_US * `CCSYS_CLK_MHZ)
`define CCSYS_DN_CYC          (`CCSYS_DN_DELAY_US * `CCSYS_CLK_MHZ)
`define CCSYS_CNT_W           16

`endif

// [hw/ccsys_pkg.sv]
package ccsys_pkg;
  typedef logic [31:0] ccsys_word_t;
  typedef enum logic [1:0] {
    CCSYS_PWR_IDLE,
    CCSYS_PWR_STREAM,
    CCSYS_PWR_WAIT
  } ccsys_pwr_e;
endpackage

// [hw/ccsys_settle.sv]
`timescale 1ns/1ns
`include "ccsys_consts.svh"

module ccsys_settle
  import ccsys_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     start_i,
  input  wire logic [`CCSYS_CNT_W-1:0]  cycles_i,
  output logic                          busy_o
);

  logic [`CCSYS_CNT_W-1:0] count;

  // Start restarts the wait even while one is running
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else if (start_i) begin
      count <= cycles_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign busy_o = (count != '0);

endmodule

// [hw/ccsys_top.sv]
// Operation
// - Bit 11 high while power stream runs
// - Bit 10 high during power-up settling
// - Bit 9 high during power-down settling
// - Bit 8 mirrors card probe, resets zero
// - Bits 7 and 2 read zero
// - Bit 6 gates idle card clock
// - Bit 5 locks ID registers, resets one
// - Bit 4 routes card parity to SERR
// - Bit 3 plus routing enables central DMA
// - Bit 1 refuses clock-run stops
// - Mux zero: ring and PME, ring first
// - Mux one: only PME on terminal
// - Routing register at 8Ch, resets zero
// - All terminals inputs after reset
// - Routing default loadable from EEPROM
// - Routing bits 31-28 read zero
// - Bits 27-24 select terminal 6 function
`timescale 1ns/1ns
`include "ccsys_consts.svh"

module ccsys_top
  import ccsys_pkg::*;
(
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RST_B_I,
  input  wire logic [`CCSYS_ADDR_W-1:0] ADDR_I,
  input  wire logic [31:0]              WDATA_I,
  input  wire logic                     WR_I,
  input  wire logic                     RD_I,
  output logic      [31:0]              RDATA_O,
  input  wire logic                     PWR_REQ_I,
  input  wire logic                     PWR_UP_I,
  input  wire logic                     STREAM_DONE_I,
  input  wire logic                     CARD_PROBE_I,
  input  wire logic                     CARD_IDLE_I,
  input  wire logic                     CARD_CLK_STOPPED_I,
  output logic                          CARD_SM_CLK_EN_O,
  output logic                          ID_WRITE_EN_O,
  input  wire logic                     CARD_PARITY_ERR_I,
  output logic                          SERR_REQ_O,
  input  wire logic                     CDMA_ROUTED_I,
  output logic                          CENTRAL_DMA_EN_O,
  input  wire logic                     PCI_STOP_REQ_I,
  input  wire logic                     CARD_STOP_REQ_I,
  output logic                          PCI_STOP_ALLOW_O,
  output logic                          CARD_STOP_ALLOW_O,
  input  wire logic                     RING_I,
  input  wire logic                     RING_EN_I,
  input  wire logic                     PME_I,
  input  wire logic                     PME_EN_I,
  output logic                          RING_PME_O,
  input  wire logic                     EE_LOAD_I,
  input  wire logic [31:0]              EE_DATA_I,
  input  wire logic                     CLKRUN_IN_I,
  input  wire logic                     CLKRUN_DRV_I,
  input  wire logic [15:0]              ISA_IRQ_I,
  output logic                          MP6_O,
  output logic                          MP6_OE_B_O,
  output logic                          CLKRUN_O
);

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  ccsys_word_t system_control_low;
  ccsys_word_t pin_function_select;
  ccsys_pwr_e  pwr_state;
  logic        pwr_dir_up;
  logic        up_start;
  logic        dn_start;
  logic        power_up_wait;
  logic        power_down_wait;
  logic        power_stream_busy;
  logic        idle_clock_gate_en;
  logic        id_write_lock;
  logic        card_parity_serr_en;
  logic        central_dma_en;
  logic        clock_hold;
  logic        ring_pme_mux_sel;
  logic        card_probe_busy;
  logic        wr_sys;
  logic        wr_route;
  logic [3:0]  multipin6_select;

  function automatic ccsys_word_t merge_w(input ccsys_word_t old_v,
                                          input ccsys_word_t new_v,
                                          input ccsys_word_t mask);
    merge_w = (old_v & ~mask) | (new_v & mask);
  endfunction

  assign wr_sys   = WR_I && (ADDR_I == `CCSYS_OFS_SYSCTL);
  assign wr_route = WR_I && (ADDR_I == `CCSYS_OFS_ROUTING);

  // Only the writable enables are stored; status bits live elsewhere
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      system_control_low <= `CCSYS_SYSCTL_RST;
    end else if (wr_sys) begin
      system_control_low <= merge_w(system_control_low, WDATA_I,
                                    `CCSYS_SYSCTL_WMASK);
    end
  end

  // EEPROM load wins over a software write in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_function_select <= `CCSYS_ROUTE_RST;
    end else if (EE_LOAD_I) begin
      pin_function_select <= EE_DATA_I & `CCSYS_ROUTE_WMASK;
    end else if (wr_route) begin
      pin_function_select <= merge_w(pin_function_select, WDATA_I,
                                     `CCSYS_ROUTE_WMASK);
    end
  end

  // --------------------------------------------------------------------
  // Power switch stream and settling
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwr_state  <= CCSYS_PWR_IDLE;
      pwr_dir_up <= 1'b0;
    end else begin
      unique case (pwr_state)
        CCSYS_PWR_IDLE: begin
          if (PWR_REQ_I) begin
            pwr_state  <= CCSYS_PWR_STREAM;
            pwr_dir_up <= PWR_UP_I;
          end
        end
        CCSYS_PWR_STREAM: begin
          if (STREAM_DONE_I) begin
            pwr_state <= CCSYS_PWR_WAIT;
          end
        end
        CCSYS_PWR_WAIT: begin
          pwr_state <= CCSYS_PWR_IDLE;
        end
      endcase
    end
  end

  // The wait starts the cycle after the stream ends
  assign up_start = (pwr_state == CCSYS_PWR_WAIT) && pwr_dir_up;
  assign dn_start = (pwr_state == CCSYS_PWR_WAIT) && !pwr_dir_up;
  assign power_stream_busy = (pwr_state == CCSYS_PWR_STREAM);

  ccsys_settle u_up (
    .clk_i    (CORE_CLK_I),
    .rst_b_i  (RST_B_I),
    .start_i  (up_start),
    .cycles_i (`CCSYS_CNT_W'(`CCSYS_UP_CYC)),
    .busy_o   (power_up_wait)
  );

  ccsys_settle u_dn (
    .clk_i    (CORE_CLK_I),
    .rst_b_i  (RST_B_I),
    .start_i  (dn_start),
    .cycles_i (`CCSYS_CNT_W'(`CCSYS_DN_CYC)),
    .busy_o   (power_down_wait)
  );

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      card_probe_busy <= 1'b0;
    end else begin
      card_probe_busy <= CARD_PROBE_I;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RD_I) begin
      if (ADDR_I == `CCSYS_OFS_SYSCTL) begin
        RDATA_O <= (system_control_low & `CCSYS_SYSCTL_WMASK)
          | (32'(power_stream_busy) << `CCSYS_B_STREAM)
          | (32'(power_up_wait) << `CCSYS_B_UPWAIT)
          | (32'(power_down_wait) << `CCSYS_B_DNWAIT)
          | (32'(card_probe_busy) << `CCSYS_B_PROBE);
      end else if (ADDR_I == `CCSYS_OFS_ROUTING) begin
        RDATA_O <= pin_function_select & `CCSYS_ROUTE_WMASK;
      end else begin
        RDATA_O <= 32'h00000000;
      end
    end else begin
      RDATA_O <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------------
  assign idle_clock_gate_en  = system_control_low[`CCSYS_B_GATE];
  assign id_write_lock       = system_control_low[`CCSYS_B_IDLOCK];
  assign card_parity_serr_en = system_control_low[`CCSYS_B_PARSERR];
  assign central_dma_en      = system_control_low[`CCSYS_B_CDMA];
  assign clock_hold          = system_control_low[`CCSYS_B_HOLD];
  assign ring_pme_mux_sel    = system_control_low[`CCSYS_B_RING_PME_MUX];

  assign CARD_SM_CLK_EN_O = !(idle_clock_gate_en && CARD_IDLE_I
                              && CARD_CLK_STOPPED_I);
  assign ID_WRITE_EN_O    = !id_write_lock;
  // Parity error only reaches SERR when reporting is enabled
  assign SERR_REQ_O       = card_parity_serr_en && CARD_PARITY_ERR_I;
  assign CENTRAL_DMA_EN_O = central_dma_en && CDMA_ROUTED_I;
  assign PCI_STOP_ALLOW_O  = PCI_STOP_REQ_I && !clock_hold;
  assign CARD_STOP_ALLOW_O = CARD_STOP_REQ_I && !clock_hold;

  always_comb begin
    if (ring_pme_mux_sel) begin
      RING_PME_O = PME_EN_I && PME_I;
    end else if (RING_EN_I) begin
      RING_PME_O = RING_I;
    end else begin
      RING_PME_O = PME_EN_I && PME_I;
    end
  end

  // --------------------------------------------------------------------
  // Terminal 6
  // --------------------------------------------------------------------
  assign multipin6_select = pin_function_select[`CCSYS_MP6_LSB +: 4];

  // Code 0 leaves the pin floating; clock-run is open-drain style
  always_comb begin
    MP6_O      = 1'b0;
    MP6_OE_B_O = 1'b1;
    CLKRUN_O   = 1'b0;
    if (multipin6_select == `CCSYS_MP6_CLKRUN) begin
      CLKRUN_O   = CLKRUN_IN_I;
      MP6_OE_B_O = !CLKRUN_DRV_I;
    end else if (multipin6_select != 4'h0) begin
      MP6_O      = ISA_IRQ_I[multipin6_select];
      MP6_OE_B_O = 1'b0;
    end
  end

endmodule

// [tb/ccsys_top_asserts.sv]
`timescale 1ns/1ns
`include "ccsys_consts.svh"
module ccsys_top_asserts
  import ccsys_pkg::*;
(
  input wire logic                     CORE_CLK_I,
  input wire logic                     RST_B_I,
  input wire logic [`CCSYS_ADDR_W-1:0] ADDR_I,
  input wire logic                     RD_I,
  input wire logic [31:0]              RDATA_O,
  input wire logic                     ID_WRITE_EN_O,
  input wire logic                     CARD_PARITY_ERR_I,
  input wire logic                     SERR_REQ_O,
  input wire logic                     CDMA_ROUTED_I,
  input wire logic                     CENTRAL_DMA_EN_O,
  input wire logic                     PCI_STOP_REQ_I,
  input wire logic                     PCI_STOP_ALLOW_O,
  input wire logic                     CARD_STOP_REQ_I,
  input wire logic                     CARD_STOP_ALLOW_O,
  input wire logic                     MP6_OE_B_O
);
  // ----
  // Read-side and output gating checks
  // ----
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence rd_s(logic [7:0] a);
    RD_I && ADDR_I == a;
  endsequence
  chk_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data not zero outside a read");
  chk_ctl_rsvd: assert property (rd_s(`CCSYS_OFS_SYSCTL) |=>
    RDATA_O[7] == 1'b0 && RDATA_O[2] == 1'b0)
    else $error("reserved control bits read nonzero");
  chk_route_rsvd: assert property (rd_s(`CCSYS_OFS_ROUTING) |=>
    RDATA_O[31:28] == 4'h0)
    else $error("reserved routing bits read nonzero");
  chk_lock_view: assert property (rd_s(`CCSYS_OFS_SYSCTL) |=>
    RDATA_O[5] == !ID_WRITE_EN_O)
    else $error("id lock bit and id write enable disagree");
  chk_pin_input: assert property (rd_s(`CCSYS_OFS_ROUTING) ##1
    RDATA_O[27:24] == 4'h0 |-> MP6_OE_B_O)
    else $error("terminal 6 driven with default code");
  chk_serr_gate: assert property (!CARD_PARITY_ERR_I |-> !SERR_REQ_O)
    else $error("error report without parity error");
  chk_dma_gate: assert property (!CDMA_ROUTED_I |-> !CENTRAL_DMA_EN_O)
    else $error("central dma enabled without routing");
  chk_stop_gate: assert property ((!PCI_STOP_REQ_I |-> !PCI_STOP_ALLOW_O)
    and (!CARD_STOP_REQ_I |-> !CARD_STOP_ALLOW_O))
    else $error("clock stop allowed without request");
endmodule

bind ccsys_top ccsys_top_asserts chk_u (.*);

// [tb/card_ctrl_sysctl_pin_routing_tb.sv]
`timescale 1ns/1ns
`include "ccsys_consts.svh"
module card_ctrl_sysctl_pin_routing_tb;
  import ccsys_pkg::*;
  logic CORE_CLK_I, RST_B_I, WR_I, RD_I, PWR_REQ_I, PWR_UP_I, STREAM_DONE_I;
  logic CARD_PROBE_I, CARD_IDLE_I, CARD_CLK_STOPPED_I, CARD_PARITY_ERR_I;
  logic CDMA_ROUTED_I, PCI_STOP_REQ_I, CARD_STOP_REQ_I, RING_I, RING_EN_I;
  logic PME_I, PME_EN_I, EE_LOAD_I, CLKRUN_IN_I, CLKRUN_DRV_I, MP6_O;
  logic CARD_SM_CLK_EN_O, ID_WRITE_EN_O, SERR_REQ_O, CENTRAL_DMA_EN_O;
  logic PCI_STOP_ALLOW_O, CARD_STOP_ALLOW_O, RING_PME_O, MP6_OE_B_O, CLKRUN_O;
  logic [`CCSYS_ADDR_W-1:0] ADDR_I;
  logic [15:0]              ISA_IRQ_I;
  ccsys_word_t              WDATA_I, RDATA_O, EE_DATA_I, sc, rt, v, d;
  logic [31:0]              seed = 32'h0121;
  int                       errors, n_checks;
  ccsys_top dut_u (.*);
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input ccsys_word_t got, input ccsys_word_t exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input ccsys_word_t dv);
    @(posedge CORE_CLK_I);
    {WR_I, ADDR_I, WDATA_I} <= {1'b1, a, dv};
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output ccsys_word_t q);
    @(posedge CORE_CLK_I);
    {RD_I, ADDR_I} <= {1'b1, a};
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
    @(negedge CORE_CLK_I);
    q = RDATA_O;
  endtask
  // Random pin levels, outputs judged against the register model
  task automatic pins(input int n);
    logic [31:0] r;
    logic [3:0]  c;
    logic        rg;
    repeat (n) begin
      r = rnd();
      @(posedge CORE_CLK_I);
      {CARD_IDLE_I, CARD_CLK_STOPPED_I, CARD_PARITY_ERR_I, CDMA_ROUTED_I,
       PCI_STOP_REQ_I, CARD_STOP_REQ_I, RING_I, RING_EN_I, PME_I, PME_EN_I,
       CLKRUN_DRV_I, CLKRUN_IN_I} <= r[11:0];
      ISA_IRQ_I <= r[31:16];
      @(negedge CORE_CLK_I);
      chk(CARD_SM_CLK_EN_O, !(sc[6] & CARD_IDLE_I & CARD_CLK_STOPPED_I));
      chk(ID_WRITE_EN_O, !sc[5]);
      chk(SERR_REQ_O, sc[4] & CARD_PARITY_ERR_I);
      chk(CENTRAL_DMA_EN_O, sc[3] & CDMA_ROUTED_I);
      chk({PCI_STOP_ALLOW_O, CARD_STOP_ALLOW_O},
          {PCI_STOP_REQ_I, CARD_STOP_REQ_I} & ~{2{sc[1]}});
      rg = PME_I & PME_EN_I;
      if (!sc[0] && RING_EN_I) rg = RING_I;
      chk(RING_PME_O, rg);
      c = rt[27:24];
      chk(MP6_OE_B_O, c == 4'h0 || (c == 4'h1 && !CLKRUN_DRV_I));
      chk(MP6_O, c > 4'h1 && ISA_IRQ_I[c]);
      chk(CLKRUN_O, c == 4'h1 && CLKRUN_IN_I);
    end
  endtask
  initial begin
    CORE_CLK_I = 1'b0;
    forever #10 CORE_CLK_I = ~CORE_CLK_I;
  end
  initial begin
    #(20 * 40000);
    errors++;
    conclude();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {WR_I, RD_I, PWR_REQ_I, PWR_UP_I, STREAM_DONE_I, CARD_PROBE_I, EE_LOAD_I,
     CARD_IDLE_I, CARD_CLK_STOPPED_I, CARD_PARITY_ERR_I, CDMA_ROUTED_I,
     PCI_STOP_REQ_I, CARD_STOP_REQ_I, RING_I, RING_EN_I, PME_I, PME_EN_I,
     CLKRUN_IN_I, CLKRUN_DRV_I, RST_B_I} = '0;
    {ADDR_I, ISA_IRQ_I, WDATA_I, EE_DATA_I} = '0;
    repeat (20) @(posedge CORE_CLK_I);
    RST_B_I <= 1'b1;
    sc = `CCSYS_SYSCTL_RST;
    rt = `CCSYS_ROUTE_RST;
    rd(`CCSYS_OFS_SYSCTL, v);
    chk(v, 32'h00000020);
    rd(`CCSYS_OFS_ROUTING, v);
    chk(v, 32'h00000000);
    rd(8'h44, v);
    chk(v, 32'h00000000);
    pins(4);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      wr(`CCSYS_OFS_SYSCTL, d);
      sc = d & 32'h0000007B;
      d = rnd();
      d[27:24] = i[3:0];
      wr(`CCSYS_OFS_ROUTING, d);
      rt = d & 32'h0FFFFFFF;
      wr(8'h44, rnd());
      rd(`CCSYS_OFS_SYSCTL, v);
      chk(v, sc);
      rd(`CCSYS_OFS_ROUTING, v);
      chk(v, rt);
      pins(6);
    end
    $display("register test done");
    @(posedge CORE_CLK_I);
    CARD_PROBE_I <= 1'b1;
    repeat (2) @(posedge CORE_CLK_I);
    rd(`CCSYS_OFS_SYSCTL, v);
    chk(v[8], 1'b1);
    @(posedge CORE_CLK_I);
    CARD_PROBE_I <= 1'b0;
    repeat (2) @(posedge CORE_CLK_I);
    rd(`CCSYS_OFS_SYSCTL, v);
    chk(v[8], 1'b0);
    for (int u = 0; u < 2; u++) begin
      @(posedge CORE_CLK_I);
      {PWR_REQ_I, PWR_UP_I} <= {1'b1, u[0]};
      @(posedge CORE_CLK_I);
      PWR_REQ_I <= 1'b0;
      rd(`CCSYS_OFS_SYSCTL, v);
      chk(v[11:9], 3'b100);
      @(posedge CORE_CLK_I);
      STREAM_DONE_I <= 1'b1;
      @(posedge CORE_CLK_I);
      STREAM_DONE_I <= 1'b0;
      repeat (3) @(posedge CORE_CLK_I);
      rd(`CCSYS_OFS_SYSCTL, v);
      chk(v[11:9], u ? 3'b010 : 3'b001);
      repeat ((u ? `CCSYS_UP_CYC : `CCSYS_DN_CYC) - 10) @(posedge CORE_CLK_I);
      rd(`CCSYS_OFS_SYSCTL, v);
      chk(v[11:9], u ? 3'b010 : 3'b001);
      repeat (10) @(posedge CORE_CLK_I);
      rd(`CCSYS_OFS_SYSCTL, v);
      chk(v[11:9], 3'b000);
    end
    $display("status test done");
    @(posedge CORE_CLK_I);
    {EE_LOAD_I, EE_DATA_I} <= {1'b1, 32'hFFFFFFFF};
    @(posedge CORE_CLK_I);
    EE_LOAD_I <= 1'b0;
    rt = 32'h0FFFFFFF;
    rd(`CCSYS_OFS_ROUTING, v);
    chk(v, rt);
    pins(8);
    $display("load test done");
    @(posedge CORE_CLK_I);
    RST_B_I <= 1'b0;
    repeat (3) @(posedge CORE_CLK_I);
    RST_B_I <= 1'b1;
    sc = `CCSYS_SYSCTL_RST;
    rt = `CCSYS_ROUTE_RST;
    rd(`CCSYS_OFS_SYSCTL, v);
    chk(v, 32'h00000020);
    rd(`CCSYS_OFS_ROUTING, v);
    chk(v, 32'h00000000);
    pins(4);
    $display("second reset test done");
    conclude();
  end
endmodule
